// file: rtl/bscd_top.sv
/*
 * Backplane serial clock driver: the 16 MHz system clock line and the
 * serial link clock line with selectable base stage and drive disconnect.
 * Assumes synchronous straps on I_STAGE_SEL and I_SER_DRV_EN.
 */
`timescale 1ns/1ps
`default_nettype none
module bscd_top
    import bscd_pkg::*;
#(
    parameter int P_STAGE_N = STAGE_N
)
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic [$clog2(P_STAGE_N)-1:0] I_STAGE_SEL,
    input wire logic I_SER_DRV_EN,
    output logic O_SYSTEM_CLOCK_LINE,
    output logic O_SERIAL_LINK_CLOCK_LINE,
    output logic O_SERIAL_LINK_CLOCK_LINE_OE
);

    ////////////////////////////////////////////////////////////////////////
    generate
        if (P_STAGE_N < 2)
        begin : g_bad_stage
            $error("Stage count must be at least two.");
        end

        if (SER_PERIOD_PS < SER_PERIOD_MIN_NS * 1000 ||
            SER_PERIOD_PS > SER_PERIOD_MAX_NS * 1000)
        begin : g_bad_period
            $error("Serial period outside its bounds.");
        end

        if (SRC_RATE_HZ > CLK_RATE_HZ)
        begin : g_bad_rate
            $error("Source rate above system clock rate.");
        end

        // Both rates must be whole multiples of the accumulator unit, or
        // the source tick rate would drift from its nominal value.
        if (SRC_RATE_HZ % RATE_UNIT_HZ != 0 ||
            CLK_RATE_HZ % RATE_UNIT_HZ != 0)
        begin : g_bad_unit
            $error("Clock rates not whole multiples of the rate unit.");
        end

        if (ACC_INC == '0)
        begin : g_bad_inc
            $error("Accumulator step must not be zero.");
        end

        // The sum may reach the modulus plus the step less one; it must not
        // wrap, or a source tick would be lost.
        if (int'(ACC_MOD) + int'(ACC_INC) > (1 << ACC_W))
        begin : g_bad_acc
            $error("Accumulator too narrow for its modulus.");
        end

        if (SER_HIGH_SRC == '0 || SER_HIGH_SRC >= SER_PERIOD_SRC)
        begin : g_bad_split
            $error("Serial high phase must leave a low phase.");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    bscd_tick_if #(.P_STAGE_N(P_STAGE_N)) tick ();

    bscd_tick_gen #(.P_STAGE_N(P_STAGE_N)) u_tick_gen (
        .i_clk(I_CLK_SYS),
        .i_rst_n(I_RST_N),
        .tick(tick)
    );

    function automatic logic sel_tick(
        input logic [P_STAGE_N-1:0] ticks,
        input logic [$clog2(P_STAGE_N)-1:0] sel
    );
        sel_tick = 1'b0;
        if (int'(sel) < P_STAGE_N)
        begin
            sel_tick = ticks[sel];
        end
    endfunction

    // Shared end-of-phase test of both serial clock halves; a phase of n
    // base ticks ends on the tick that finds its count at n minus one.
    function automatic logic phase_done(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] len
    );
        phase_done = (cnt == len - 1'b1);
    endfunction

    logic base_tick;
    assign base_tick = sel_tick(tick.stage_tick, I_STAGE_SEL);

    ////////////////////////////////////////////////////////////////////////
    // The system clock toggles on every source tick, giving 16 MHz on
    // average; it runs from reset on and depends on no bus input.
    logic sys_clk_reg;

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            sys_clk_reg <= 1'b0;
        end
        else if (tick.src_tick)
        begin
            sys_clk_reg <= ~sys_clk_reg;
        end
    end

    assign O_SYSTEM_CLOCK_LINE = sys_clk_reg;

    ////////////////////////////////////////////////////////////////////////
    // The serial waveform advances only on base ticks, so it keeps no
    // fixed relation to any bus signal.
    bscd_ser_state_t ser_state_reg;
    bscd_ser_state_t ser_state_next;
    logic [CNT_W-1:0] ser_cnt_reg;
    logic [CNT_W-1:0] ser_cnt_next;

    always_comb
    begin
        ser_state_next = ser_state_reg;
        ser_cnt_next = ser_cnt_reg;
        if (base_tick)
        begin
            ser_cnt_next = ser_cnt_reg + 1'b1;
            case (ser_state_reg)
                BSCD_SER_HIGH:
                begin
                    if (phase_done(ser_cnt_reg, SER_HIGH_SRC))
                    begin
                        ser_state_next = BSCD_SER_LOW;
                        ser_cnt_next = '0;
                    end
                end
                BSCD_SER_LOW:
                begin
                    if (phase_done(ser_cnt_reg, SER_LOW_SRC))
                    begin
                        ser_state_next = BSCD_SER_HIGH;
                        ser_cnt_next = '0;
                    end
                end
                default:
                begin
                    ser_state_next = BSCD_SER_HIGH;
                    ser_cnt_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ser_state_reg <= BSCD_SER_HIGH;
        end
        else
        begin
            ser_state_reg <= ser_state_next;
        end
    end

    // The counter restarts at each phase end, so it never needs to wrap.
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ser_cnt_reg <= '0;
        end
        else
        begin
            ser_cnt_reg <= ser_cnt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output stage: the line and its enable are registered together so
    // that a disconnect never leaves a half-cycle glitch on the backplane.
    logic ser_line_reg;
    logic ser_oe_reg;

    // The enable follows the strap alone, one cycle late, like the line.
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ser_oe_reg <= 1'b0;
        end
        else
        begin
            ser_oe_reg <= I_SER_DRV_EN;
        end
    end

    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            ser_line_reg <= 1'b0;
        end
        else
        begin
            ser_line_reg <= I_SER_DRV_EN &
                (ser_state_next == BSCD_SER_HIGH);
        end
    end

    assign O_SERIAL_LINK_CLOCK_LINE = ser_line_reg;
    assign O_SERIAL_LINK_CLOCK_LINE_OE = ser_oe_reg;

endmodule
`default_nettype wire

// file: rtl/bscd_pkg.sv
/*
 * Shared constants of the backplane serial clock driver: clock rates,
 * divider stages and the serial clock waveform, in source cycles.
 * Assumes a single system clock and a board reset; no software access.
 */
//
// Functional notes
// - Drive a constant free-running 16 MHz system clock, independent of bus signals; here 16 MHz only on average, each period two or three system cycles.
// - Serial clock relates to no bus signal except the serial data line.
// - Derive the serial clock waveform from a 32 MHz source clock.
// - Serial clock full cycle must lie between 340 and 347 ns; at the base stage 343.75 ns on average, single cycles 325 or 350 ns.
// - Off-backplane links scale every serial timing value by one common factor.
// - Base frequency selected from binary counter stages: 32, 16, 8 MHz and on.
// - The same 32 MHz source is divided to make the 16 MHz system clock.
// - An option disconnects the serial clock driver from its line.
package bscd_pkg;

    localparam longint CLK_RATE_HZ = 40_000_000;
    localparam longint SRC_RATE_HZ = 32_000_000;
    localparam longint RATE_UNIT_HZ = 8_000_000;
    localparam int ACC_W = 4;
    localparam logic [ACC_W-1:0] ACC_INC = ACC_W'(SRC_RATE_HZ / RATE_UNIT_HZ);
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_RATE_HZ / RATE_UNIT_HZ);
    localparam logic [ACC_W-1:0] ACC_RESET = 4'h0;

    localparam int STAGE_N = 4;

    localparam longint SER_PERIOD_MIN_NS = 340;
    localparam longint SER_PERIOD_MAX_NS = 347;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] SER_PERIOD_SRC = 4'hb;
    localparam logic [CNT_W-1:0] SER_HIGH_SRC = 4'h6;
    localparam logic [CNT_W-1:0] SER_LOW_SRC = SER_PERIOD_SRC - SER_HIGH_SRC;
    localparam longint SER_PERIOD_PS =
        longint'(SER_PERIOD_SRC) * 64'd1_000_000_000_000 / SRC_RATE_HZ;

    typedef enum logic {BSCD_SER_HIGH, BSCD_SER_LOW} bscd_ser_state_t;

endpackage

// file: rtl/bscd_tick_if.sv
/*
 * Carrier between the tick generator and the driver top.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bscd_tick_if #(parameter int P_STAGE_N = 4);
    logic src_tick;
    logic [P_STAGE_N-1:0] stage_tick;
    modport gen (output src_tick, output stage_tick);
    modport use_side (input src_tick, input stage_tick);
endinterface
`default_nettype wire

// file: rtl/bscd_tick_gen.sv
/*
 * Source tick generator: a fractional accumulator makes 32 MHz ticks from
 * the 40 MHz system clock, and a binary counter yields one tick per stage.
 * Assumes the system clock rate is at least the source rate.
 */
`timescale 1ns/1ps
`default_nettype none
module bscd_tick_gen
    import bscd_pkg::*;
#(
    parameter int P_STAGE_N = STAGE_N
)
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    bscd_tick_if.gen tick
);

    ////////////////////////////////////////////////////////////////////////
    // The accumulator spreads the source ticks evenly; each tick period is
    // one or two system cycles, which is the price of a single clock.
    logic [ACC_W-1:0] acc_reg;
    logic [ACC_W-1:0] acc_sum;
    logic [P_STAGE_N-2:0] cnt_reg;

    assign acc_sum = acc_reg + ACC_INC;
    assign tick.src_tick = (acc_sum >= ACC_MOD);

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            acc_reg <= ACC_RESET;
        end
        else if (tick.src_tick)
        begin
            acc_reg <= acc_sum - ACC_MOD;
        end
        else
        begin
            acc_reg <= acc_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cnt_reg <= '0;
        end
        else if (tick.src_tick)
        begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign tick.stage_tick[0] = tick.src_tick;
    genvar k;
    generate
        for (k = 1; k < P_STAGE_N; k++)
        begin : g_stage
            assign tick.stage_tick[k] = tick.src_tick & (&cnt_reg[k-1:0]);
        end
    endgenerate

endmodule
`default_nettype wire

// file: testbench/bscd_monitor.sv
/* Port checker of the clock driver top, attached by bind.
   Assumes the top's clock and low-active asynchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module bscd_monitor #(parameter int P_STAGE_N = 4)
(
    input wire logic I_CLK_SYS,
    input wire logic I_RST_N,
    input wire logic [$clog2(P_STAGE_N)-1:0] I_STAGE_SEL,
    input wire logic I_SER_DRV_EN,
    input wire logic O_SYSTEM_CLOCK_LINE,
    input wire logic O_SERIAL_LINK_CLOCK_LINE,
    input wire logic O_SERIAL_LINK_CLOCK_LINE_OE
);
    logic ln_q;
    logic en_q;
    logic [4:0] run_q;
    logic [4:0] age_q;
    logic [$clog2(P_STAGE_N)-1:0] sel_q;
    // Run lengths jitter by a cycle, so only runs after settled straps count.
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
        if (!I_RST_N) run_q <= 5'h0;
        else run_q <= (O_SERIAL_LINK_CLOCK_LINE != ln_q) ? 5'h1
            : run_q + 5'(run_q != 5'h1f);
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
        if (!I_RST_N) ln_q <= 1'b0;
        else ln_q <= O_SERIAL_LINK_CLOCK_LINE;
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
        if (!I_RST_N) age_q <= 5'h0;
        else age_q <= (I_STAGE_SEL != sel_q || I_SER_DRV_EN != en_q) ? 5'h0
            : age_q + 5'(age_q != 5'h1f);
    always_ff @(posedge I_CLK_SYS)
        {sel_q, en_q} <= {I_STAGE_SEL, I_SER_DRV_EN};
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);
    sequence s_end;
        $changed(O_SERIAL_LINK_CLOCK_LINE) && age_q >= 5'h10;
    endsequence
    sequence s_hi(k);
        s_end ##0 !O_SERIAL_LINK_CLOCK_LINE && I_STAGE_SEL == k;
    endsequence
    sequence s_lo(k);
        s_end ##0 O_SERIAL_LINK_CLOCK_LINE && I_STAGE_SEL == k;
    endsequence
    a_base_high: assert property (s_hi(0) |-> run_q inside {7, 8})
        else $error("base high phase length wrong");
    a_base_low: assert property (s_lo(0) |-> run_q inside {6, 7})
        else $error("base low phase length wrong");
    a_stage_high: assert property (s_hi(1) |-> run_q inside {14, 15})
        else $error("stage one high phase length wrong");
    a_stage_low: assert property (s_lo(1) |-> run_q inside {12, 13})
        else $error("stage one low phase length wrong");
    a_sys_toggle: assert property ($stable(O_SYSTEM_CLOCK_LINE)
        && $past(I_RST_N) |=> $changed(O_SYSTEM_CLOCK_LINE))
        else $error("system clock stalled");
    a_oe_follow: assert property ($past(I_RST_N) |->
        O_SERIAL_LINK_CLOCK_LINE_OE == $past(I_SER_DRV_EN))
        else $error("drive enable not followed");
    a_line_off: assert property (!O_SERIAL_LINK_CLOCK_LINE_OE
        |-> !O_SERIAL_LINK_CLOCK_LINE) else $error("undriven line not low");
    a_en_stop: assert property ($fell(I_SER_DRV_EN)
        |=> !O_SERIAL_LINK_CLOCK_LINE [*2]) else $error("line kept running");
endmodule
bind bscd_top bscd_monitor #(.P_STAGE_N(P_STAGE_N)) u_mon (.I_CLK_SYS,
    .I_RST_N, .I_STAGE_SEL, .I_SER_DRV_EN, .O_SYSTEM_CLOCK_LINE,
    .O_SERIAL_LINK_CLOCK_LINE, .O_SERIAL_LINK_CLOCK_LINE_OE);
`default_nettype wire

// file: testbench/bscd_backplane.sv
/* Backplane model: the serial clock wire shared with a second driver board.
   Assumes the bench clock; an unowned wire flips every cycle. */
`timescale 1ns/1ps
`default_nettype none
module bscd_backplane
(
    input wire logic i_clk,
    input wire logic i_own_clk,
    input wire logic i_own_oe,
    input wire logic i_alt_en,
    output logic o_wire,
    output logic o_clash
);
    logic [2:0] div_reg = 3'h0;
    logic alt_reg = 1'b0;
    logic last_reg = 1'b0;
    // The second board runs on its own timing, toggling every 7 clocks.
    always_ff @(posedge i_clk)
        {div_reg, alt_reg} <= (div_reg == 3'h6) ? {3'h0, ~alt_reg}
            : {div_reg + 3'h1, alt_reg};
    always_ff @(posedge i_clk)
        last_reg <= o_wire;
    assign o_wire = i_own_oe ? i_own_clk : i_alt_en ? alt_reg : ~last_reg;
    assign o_clash = i_own_oe & i_alt_en;
endmodule
`default_nettype wire

// file: testbench/tb_backplane_serial_clock_driver.sv
/* Self-checking bench of the clock driver top with the backplane model.
   Assumes the default of four divider stages. */
`timescale 1ns/1ps
`default_nettype none
module tb_backplane_serial_clock_driver;
    import bscd_pkg::*;
    typedef struct packed {logic [1:0] sel; logic en; logic alt;
        logic [31:0] exp;} bscd_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] sel = 2'h0;
    logic en = 1'b1;
    logic alt = 1'b0;
    logic sys, ser, oe, wire_lvl, clash;
    logic prev_sys;
    logic [31:0] n;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;
    bscd_row_t rows [5] = '{'{2'h0, 1'b1, 1'b0, 32'd110},
        '{2'h1, 1'b1, 1'b0, 32'd220}, '{2'h2, 1'b1, 1'b0, 32'd440},
        '{2'h3, 1'b1, 1'b0, 32'd880}, '{2'h0, 1'b0, 1'b1, 32'd112}};
    bscd_top uut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_STAGE_SEL(sel),
        .I_SER_DRV_EN(en), .O_SYSTEM_CLOCK_LINE(sys),
        .O_SERIAL_LINK_CLOCK_LINE(ser), .O_SERIAL_LINK_CLOCK_LINE_OE(oe));
    bscd_backplane u_bp (.i_clk(clk), .i_own_clk(ser), .i_own_oe(oe),
        .i_alt_en(alt), .o_wire(wire_lvl), .o_clash(clash));
    initial
        forever #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %0d seen %0d", name, exp, seen);
        end
    endtask
    // Cycles spanned by eight whole periods of the wire, 0 if it never runs.
    task automatic measure(output logic [31:0] cnt);
        int rises;
        logic prev;
        cnt = 0;
        rises = 0;
        prev = wire_lvl;
        for (int i = 0; i < 2000 && rises < 9; i++)
        begin
            @(posedge clk);
            #1;
            cnt = cnt + 32'(rises > 0);
            rises = rises + int'(!prev && wire_lvl);
            prev = wire_lvl;
        end
        if (rises < 9)
            cnt = 0;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            @(posedge clk);
            {sel, en, alt} <= {rows[i].sel, rows[i].en, rows[i].alt};
            repeat (20) @(posedge clk);
            measure(n);
            check("period", n, rows[i].exp);
            check("clash", 32'(clash), 32'h0);
            check("oe", 32'(oe), 32'(rows[i].en));
        end
        n = 0;
        prev_sys = sys;
        for (int i = 0; i < 100; i++)
        begin
            @(posedge clk);
            #1;
            n = n + 32'(prev_sys !== sys);
            prev_sys = sys;
        end
        check("sys_toggles", n, 32'd80);
        @(posedge clk);
        {alt, en} <= 2'b01;
        repeat (30) @(posedge clk);
        en <= 1'b0;
        @(posedge clk);
        #1;
        check("line_off", {30'h0, ser, oe}, 32'h0);
        @(posedge clk);
        {en, rst_n} <= 2'b10;
        #1;
        check("reset_out", {29'h0, sys, ser, oe}, 32'h0);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check("rst_edge1", {29'h0, sys, ser, oe}, 32'h3);
        @(posedge clk);
        #1;
        check("rst_edge2", 32'(sys), 32'h1);
        repeat (20) @(posedge clk);
        measure(n);
        check("period_rst", n, 32'd110);
        summarize();
    end
endmodule
`default_nettype wire
